// [maint_cmd.sv]
// Maintenance command handler: command execution, fault flags, boot image and update lamps
`timescale 1ns/1ps
module maint_cmd #(
  parameter logic [31:0] FW_RELEASE = 32'h0000_0100,  // Arbitrary value
  parameter logic [31:0] FW_DATE = 32'h0000_0000,  // Arbitrary value
  parameter logic [31:0] PRODUCT_ID = 32'h1234_5678,  // Arbitrary value
  parameter logic [31:0] HW_RELEASE = 32'h4100_0001,  // Arbitrary value
  parameter int SLOW_HALF = maint_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = maint_pkg::FAST_HALF_CYC
) (
  input wire logic clk,  // 50 MHz clock
  input wire logic rst_b,  // Async reset, active low
  input wire logic [5:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,  // Write address valid
  output logic s_axi_awready,  // Write address ready
  input wire logic [31:0] s_axi_wdata,  // Write data
  input wire logic [3:0] s_axi_wstrb,  // Write strobes
  input wire logic s_axi_wvalid,  // Write data valid
  output logic s_axi_wready,  // Write data ready
  output logic [1:0] s_axi_bresp,  // Write response
  output logic s_axi_bvalid,  // Write response valid
  input wire logic s_axi_bready,  // Write response ready
  input wire logic [5:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,  // Read address valid
  output logic s_axi_arready,  // Read address ready
  output logic [31:0] s_axi_rdata,  // Read data
  output logic [1:0] s_axi_rresp,  // Read response
  output logic s_axi_rvalid,  // Read data valid
  input wire logic s_axi_rready,  // Read data ready
  input wire logic [4:0] fault_evt,  // Cmd, busy, param, other, battery events
  input wire logic [63:0] chip_status,  // Four 16-bit control chip status words
  input wire logic upd_byte_valid,  // Update file byte arrives
  input wire logic [1:0] upd_port,  // Port the byte came from
  input wire logic upd_last,  // Last byte of update file
  input wire logic prog_done,  // Nonvolatile write complete
  input wire logic key8_held,  // Numeric key 8 held at power-up
  input wire logic nv_next_img,  // Stored boot selection
  input wire logic nv_prev_img,  // Image used before the last boot
  output logic irq,  // Level interrupt
  output logic host_control_lamp,  // Remote lamp
  output logic manual_mode_lamp,  // Local lamp
  output logic verbose_off,  // Pulse: force verbose replies off on all ports
  output logic boot_select,  // Image to boot next, to storage
  output logic img_in_use,  // Image currently running
  output logic reboot,  // Pulse: restart the instrument
  output logic settings_reset,  // Pulse: positions and settings to defaults
  output logic prog_start,  // Pulse: begin nonvolatile write
  output logic [7:0] display_char  // Startup screen hardware character
);
  initial begin
    if (SLOW_HALF < 2 || FAST_HALF < 1 || FAST_HALF >= SLOW_HALF)
      $error("Blink half periods out of range");
  end

  logic rst_m_r, rst_s_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) {rst_m_r, rst_s_r} <= 2'b00;
    else {rst_m_r, rst_s_r} <= {1'b1, rst_m_r};
  end
  wire rst_sb = rst_s_r;

  // Bus slave: address and data are taken together so neither can be orphaned
  logic awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  wire rd_go = s_axi_arvalid && !arready_r && !rvalid_r;
  wire wr_en = wr_go && (&s_axi_wstrb);
  wire [5:0] wa = s_axi_awaddr;
  wire wr_cmd = wr_en && wa == maint_pkg::CMD_OFS;
  wire wr_irqs = wr_en && wa == maint_pkg::IRQ_STAT_OFS;
  wire wr_mask = wr_en && wa == maint_pkg::IRQ_MASK_OFS;
  wire wr_cfg = wr_en && wa == maint_pkg::CFG_OFS;
  wire wa_ok = wr_cmd || wr_irqs || wr_mask || wr_cfg;

  maint_pkg::op_t op;
  assign op = maint_pkg::op_t'(s_axi_wdata[7:0]);
  wire [3:0] arg = s_axi_wdata[maint_pkg::CMD_ARG_LSB +: 4];
  wire arg_present = s_axi_wdata[maint_pkg::CMD_ARG_PRESENT];
  wire op_known = s_axi_wdata[7:0] <= 8'h0a && s_axi_wdata[7:0] != 8'h00;
  wire arg_ok = !arg_present || arg <= 4'h3 || arg == 4'h7;

  // Fault flags
  logic [7:0] fault_r, fault_nxt, clr_mask, set_mask;
  wire do_clear = wr_cmd && op == maint_pkg::OP_FAULT_CLEAR && arg_ok;
  always_comb
  begin
    clr_mask = 8'h00;
    if (do_clear) clr_mask = arg_present ? (8'h01 << arg[2:0]) : 8'hff;
  end
  assign set_mask = {fault_evt[4], 3'h0, fault_evt[3:0]}
    | {5'h00, wr_cmd && op == maint_pkg::OP_FAULT_CLEAR && !arg_ok, 1'b0,
       wr_cmd && !op_known};
  assign fault_nxt = ((fault_r & ~clr_mask) | set_mask) & maint_pkg::FLT_IMPL;

  // Lowest set flag picks the text message
  maint_pkg::msg_t msg;
  always_comb
  begin
    msg = maint_pkg::MSG_NO_ERROR;
    if (fault_r[maint_pkg::FLT_BATT]) msg = maint_pkg::MSG_BATTERY;
    if (fault_r[maint_pkg::FLT_OTHER]) msg = maint_pkg::MSG_OTHER;
    if (fault_r[maint_pkg::FLT_PARAM]) msg = maint_pkg::MSG_PARAM;
    if (fault_r[maint_pkg::FLT_BUSY]) msg = maint_pkg::MSG_BUSY;
    if (fault_r[maint_pkg::FLT_CMD]) msg = maint_pkg::MSG_COMMAND;
  end

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Reply words; silent commands leave reply_valid low
  logic [31:0] rpl0_r, rpl1_r, rpl2_r, rpl0_nxt, rpl1_nxt, rpl2_nxt;
  logic reply_valid_r, is_query, img_in_use_r;
  always_comb
  begin
    rpl0_nxt = rpl0_r;
    rpl1_nxt = rpl1_r;
    rpl2_nxt = rpl2_r;
    is_query = 1'b1;
    unique case (op)
      maint_pkg::OP_FW_REL:
      begin
        rpl0_nxt = FW_RELEASE;
        rpl1_nxt = FW_DATE;
        rpl2_nxt = PRODUCT_ID;
      end
      maint_pkg::OP_HW_REL: rpl0_nxt = HW_RELEASE;
      maint_pkg::OP_CHIP_STATE:
      begin
        rpl0_nxt = chip_status[31:0];
        rpl1_nxt = chip_status[63:32];
      end
      maint_pkg::OP_FAULT_BITS:
        rpl0_nxt = {16'h0000, hex_char(fault_r[7:4]), hex_char(fault_r[3:0])};
      maint_pkg::OP_FAULT_TEXT: rpl0_nxt = {24'h000000, msg};
      maint_pkg::OP_IMG_QUERY: rpl0_nxt = {31'h0, img_in_use_r};
      default: is_query = 1'b0;
    endcase
  end

  // Boot image and restart
  logic next_img_r, start_r, reboot_r, settings_reset_r, preserve;
  logic [2:0] cfg_r;
  wire sel0 = wr_cmd && op == maint_pkg::OP_IMG0_SEL;
  wire sel1 = wr_cmd && op == maint_pkg::OP_IMG1_SEL;
  wire do_reboot = wr_cmd && op == maint_pkg::OP_REBOOT;
  assign preserve = cfg_r[maint_pkg::CFG_IMG0_NEW] && cfg_r[maint_pkg::CFG_IMG1_NEW];

  // Update sequencer
  maint_pkg::upd_t upd_r, upd_nxt;
  wire remote = cfg_r[maint_pkg::CFG_REMOTE];
  wire upd_allowed = remote && upd_port != maint_pkg::PORT_LAN_FAST;
  wire upd_reject = upd_byte_valid && upd_r == maint_pkg::UPD_IDLE && !upd_allowed;
  always_comb
  begin
    upd_nxt = upd_r;
    unique case (upd_r)
      maint_pkg::UPD_IDLE: if (upd_byte_valid && upd_allowed) upd_nxt = maint_pkg::UPD_RECV;
      maint_pkg::UPD_RECV: if (upd_byte_valid && upd_last) upd_nxt = maint_pkg::UPD_PROG;
      maint_pkg::UPD_PROG: if (prog_done) upd_nxt = maint_pkg::UPD_FIN;
      maint_pkg::UPD_FIN: upd_nxt = maint_pkg::UPD_IDLE;
    endcase
  end

  logic [$clog2(SLOW_HALF)-1:0] blink_cnt_r;
  logic slow_r, fast_r;
  wire slow_wrap = blink_cnt_r == ($clog2(SLOW_HALF))'(SLOW_HALF - 1);
  wire fast_tick = blink_cnt_r % ($clog2(SLOW_HALF))'(FAST_HALF) == '0;
  logic host_lamp_nxt;
  always_comb
  begin
    unique case (upd_r)
      maint_pkg::UPD_RECV: host_lamp_nxt = slow_r;
      maint_pkg::UPD_PROG: host_lamp_nxt = fast_r;
      maint_pkg::UPD_FIN: host_lamp_nxt = 1'b0;
      default: host_lamp_nxt = remote;
    endcase
  end

  // Interrupts
  logic [maint_pkg::EV_N-1:0] irq_stat_r, irq_mask_r, ev;
  assign ev = {wr_cmd && is_query, upd_r == maint_pkg::UPD_FIN, upd_reject,
               |(set_mask & ~fault_r)};
  logic remote_d_r, verbose_off_r, prog_start_r;

  always_ff @(posedge clk or negedge rst_sb)
  begin
    if (!rst_sb)
    begin
      fault_r <= 8'h00;
      rpl0_r <= 32'h0;
      rpl1_r <= 32'h0;
      rpl2_r <= 32'h0;
      reply_valid_r <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      cfg_r <= 3'h0;
      remote_d_r <= 1'b0;
      verbose_off_r <= 1'b0;
      upd_r <= maint_pkg::UPD_IDLE;
      prog_start_r <= 1'b0;
    end
    else
    begin
      fault_r <= fault_nxt;
      if (wr_cmd) {rpl0_r, rpl1_r, rpl2_r} <= {rpl0_nxt, rpl1_nxt, rpl2_nxt};
      if (wr_cmd) reply_valid_r <= is_query;
      irq_stat_r <= (irq_stat_r & ~(wr_irqs ? s_axi_wdata[maint_pkg::EV_N-1:0] : '0)) | ev;
      if (wr_mask) irq_mask_r <= s_axi_wdata[maint_pkg::EV_N-1:0];
      if (upd_r == maint_pkg::UPD_FIN) cfg_r[maint_pkg::CFG_REMOTE] <= 1'b0;
      else if (wr_cfg) cfg_r <= s_axi_wdata[2:0];
      remote_d_r <= remote;
      verbose_off_r <= remote && !remote_d_r;
      upd_r <= upd_nxt;
      prog_start_r <= upd_r == maint_pkg::UPD_RECV && upd_nxt == maint_pkg::UPD_PROG;
    end
  end

  always_ff @(posedge clk or negedge rst_sb)
  begin
    if (!rst_sb)
    begin
      start_r <= 1'b1;
      img_in_use_r <= 1'b0;
      next_img_r <= 1'b0;
      reboot_r <= 1'b0;
      settings_reset_r <= 1'b0;
    end
    else
    begin
      start_r <= do_reboot;
      reboot_r <= do_reboot;
      if (start_r)
      begin
        img_in_use_r <= key8_held ? nv_prev_img : nv_next_img;
        next_img_r <= nv_next_img;
      end
      else if (sel0 || sel1) next_img_r <= sel1;
      settings_reset_r <= do_reboot && next_img_r != img_in_use_r && !preserve;
    end
  end

  always_ff @(posedge clk or negedge rst_sb)
  begin
    if (!rst_sb)
    begin
      blink_cnt_r <= '0;
      slow_r <= 1'b0;
      fast_r <= 1'b0;
      host_control_lamp <= 1'b0;
      manual_mode_lamp <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      blink_cnt_r <= slow_wrap ? '0 : blink_cnt_r + 1'b1;
      if (slow_wrap) slow_r <= !slow_r;
      if (fast_tick) fast_r <= !fast_r;
      host_control_lamp <= host_lamp_nxt;
      manual_mode_lamp <= !remote && upd_r != maint_pkg::UPD_FIN;
      irq <= |((irq_stat_r | ev) & irq_mask_r);
    end
  end

  maint_pkg::stat_t stat;
  assign stat = '{zero: '0, phase: upd_r, remote: remote, next_img: next_img_r,
                  img_in_use: img_in_use_r, reply_valid: reply_valid_r};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      maint_pkg::RPL0_OFS: rd_mux = rpl0_r;
      maint_pkg::RPL1_OFS: rd_mux = rpl1_r;
      maint_pkg::RPL2_OFS: rd_mux = rpl2_r;
      maint_pkg::STAT_OFS: rd_mux = stat;
      maint_pkg::FAULT_OFS: rd_mux = {24'h0, fault_r};
      maint_pkg::IRQ_STAT_OFS: rd_mux = {28'h0, irq_stat_r};
      maint_pkg::IRQ_MASK_OFS: rd_mux = {28'h0, irq_mask_r};
      maint_pkg::CFG_OFS: rd_mux = {29'h0, cfg_r};
      default:
      begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sb)
  begin
    if (!rst_sb)
    begin
      {awready_r, bvalid_r, arready_r, rvalid_r} <= 4'h0;
      bresp_r <= maint_pkg::RESP_OKAY;
      rresp_r <= maint_pkg::RESP_OKAY;
      rdata_r <= 32'h0;
    end
    else
    begin
      awready_r <= wr_go;
      if (wr_go) bresp_r <= wa_ok ? maint_pkg::RESP_OKAY : maint_pkg::RESP_SLVERR;
      bvalid_r <= wr_go || (bvalid_r && !s_axi_bready);
      arready_r <= rd_go;
      if (rd_go) rdata_r <= rd_mux;
      if (rd_go) rresp_r <= rd_ok ? maint_pkg::RESP_OKAY : maint_pkg::RESP_SLVERR;
      rvalid_r <= rd_go || (rvalid_r && !s_axi_rready);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign verbose_off = verbose_off_r;
  assign boot_select = next_img_r;
  assign img_in_use = img_in_use_r;
  assign reboot = reboot_r;
  assign settings_reset = settings_reset_r;
  assign prog_start = prog_start_r;
  assign display_char = HW_RELEASE[31:24];

  property clear_one_p;
    @(posedge clk) disable iff (!rst_sb)
    (do_clear && arg_present && set_mask == 8'h00) |=> !fault_r[arg[2:0]];
  endproperty
  clear_one_a: assert property (clear_one_p) else $error("Flag not cleared");
  sticky_flag_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (fault_r != 8'h00 && !do_clear) |=> (fault_r & $past(fault_r)) == $past(fault_r))
    else $error("Flag dropped without clear");
  text_lowest_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (wr_cmd && op == maint_pkg::OP_FAULT_TEXT && fault_r[0]) |=> rpl0_r == 32'h1)
    else $error("Wrong fault text");
  text_none_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (wr_cmd && op == maint_pkg::OP_FAULT_TEXT && fault_r == 8'h00) |=> rpl0_r == 32'h0)
    else $error("Expected no-error text");
  silent_cmds_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (wr_cmd && (sel0 || sel1 || do_reboot || do_clear)) |=> !reply_valid_r)
    else $error("Silent command replied");
  reboot_img_a: assert property (@(posedge clk) disable iff (!rst_sb)
    do_reboot |=> reboot ##1 (img_in_use_r == (key8_held ? $past(nv_prev_img) : $past(nv_next_img))))
    else $error("Reboot image wrong");
  fast_reject_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (upd_r == maint_pkg::UPD_IDLE && upd_byte_valid && upd_port == maint_pkg::PORT_LAN_FAST)
    |=> upd_r == maint_pkg::UPD_IDLE) else $error("Fast port upload accepted");
  local_ignore_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (upd_r == maint_pkg::UPD_IDLE && !remote) |=> upd_r == maint_pkg::UPD_IDLE)
    else $error("Upload accepted in local");
  verbose_off_a: assert property (@(posedge clk) disable iff (!rst_sb)
    $rose(remote) |=> verbose_off ##1 !verbose_off) else $error("Verbose not forced");
  lamp_order_a: assert property (@(posedge clk) disable iff (!rst_sb)
    (upd_r == maint_pkg::UPD_PROG && prog_done) |=> ##1 !host_control_lamp && !manual_mode_lamp
    ##1 !host_control_lamp ##1 manual_mode_lamp) else $error("Lamp order wrong");
  preserve_a: assert property (@(posedge clk) disable iff (!rst_sb)
    settings_reset |-> !$past(preserve)) else $error("Settings reset despite recent images");
  upd_full_c: cover property (@(posedge clk) disable iff (!rst_sb)
    upd_r == maint_pkg::UPD_RECV ##[1:20] upd_r == maint_pkg::UPD_FIN);
  reject_c: cover property (@(posedge clk) disable iff (!rst_sb) upd_reject);
  clear_c: cover property (@(posedge clk) disable iff (!rst_sb) do_clear && !arg_present);
  reboot_c: cover property (@(posedge clk) disable iff (!rst_sb) sel1 ##[1:10] do_reboot);
endmodule

// [maint_pkg.sv]
// Package: register map, encodings and timing for the maintenance command handler
package maint_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] CMD_OFS = 6'h00;
  localparam logic [5:0] RPL0_OFS = 6'h04;
  localparam logic [5:0] RPL1_OFS = 6'h08;
  localparam logic [5:0] RPL2_OFS = 6'h0c;
  localparam logic [5:0] STAT_OFS = 6'h10;
  localparam logic [5:0] FAULT_OFS = 6'h14;
  localparam logic [5:0] IRQ_STAT_OFS = 6'h18;
  localparam logic [5:0] IRQ_MASK_OFS = 6'h1c;
  localparam logic [5:0] CFG_OFS = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Command word fields
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_ARG_PRESENT = 12;
  // Fault bit positions
  localparam int FLT_CMD = 0;
  localparam int FLT_BUSY = 1;
  localparam int FLT_PARAM = 2;
  localparam int FLT_OTHER = 3;
  localparam int FLT_BATT = 7;
  localparam logic [7:0] FLT_IMPL = 8'h8f;
  // Interrupt event positions
  localparam int EV_FAULT = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_UPD_DONE = 2;
  localparam int EV_REPLY = 3;
  localparam int EV_N = 4;
  // Config register bits
  localparam int CFG_REMOTE = 0;
  localparam int CFG_IMG0_NEW = 1;
  localparam int CFG_IMG1_NEW = 2;
  // Update source ports
  localparam logic [1:0] PORT_SERIAL = 2'h0;
  localparam logic [1:0] PORT_LAN_NORMAL = 2'h1;
  localparam logic [1:0] PORT_LAN_FAST = 2'h2;
  // Lamp blink timing
  localparam longint CLK_HZ = 50_000_000;
  localparam longint SLOW_HALF_MS = 500;
  localparam longint FAST_HALF_MS = 100;
  localparam int SLOW_HALF_CYC = int'(SLOW_HALF_MS * CLK_HZ / 1000);
  localparam int FAST_HALF_CYC = int'(FAST_HALF_MS * CLK_HZ / 1000);

  typedef enum logic [7:0] {
    OP_NOP = 8'h00,
    OP_FW_REL = 8'h01,
    OP_HW_REL = 8'h02,
    OP_CHIP_STATE = 8'h03,
    OP_FAULT_BITS = 8'h04,
    OP_FAULT_TEXT = 8'h05,
    OP_FAULT_CLEAR = 8'h06,
    OP_IMG_QUERY = 8'h07,
    OP_IMG0_SEL = 8'h08,
    OP_IMG1_SEL = 8'h09,
    OP_REBOOT = 8'h0a
  } op_t;

  typedef enum logic [7:0] {
    MSG_NO_ERROR = 8'h00,
    MSG_COMMAND = 8'h01,
    MSG_BUSY = 8'h02,
    MSG_PARAM = 8'h03,
    MSG_OTHER = 8'h04,
    MSG_BATTERY = 8'h05
  } msg_t;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_RECV = 2'b01,
    UPD_PROG = 2'b10,
    UPD_FIN = 2'b11
  } upd_t;

  typedef struct packed {
    logic [25:0] zero;
    upd_t phase;
    logic remote;
    logic next_img;
    logic img_in_use;
    logic reply_valid;
  } stat_t;
endpackage

// [maintenance_command_handler_tb.sv]
// Self-checking bench for the maintenance command handler
`timescale 1ns/1ps
module maintenance_command_handler_tb;
  localparam logic [31:0] FWR = 32'h0000_0203;  // Arbitrary value
  localparam logic [31:0] FWD = 32'h0020_0101;  // Arbitrary value
  localparam logic [31:0] PID = 32'h0000_00a5;  // Arbitrary value
  localparam logic [31:0] HWR = 32'h4800_0007;  // Arbitrary value
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, key8_held = 1'h0, nv_next_img = 1'h0;
  logic [31:0] s_axi_wdata = '0, rd_d;
  logic [4:0] fault_evt = '0;
  logic [63:0] chip_status = 64'h4444_3333_2222_1111;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic host_control_lamp, manual_mode_lamp, verbose_off, boot_select, img_in_use;
  logic reboot, settings_reset, prog_start, upd_byte_valid, upd_last, prog_done, lamp_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, upd_port;
  logic [31:0] s_axi_rdata;
  logic [7:0] display_char;
  int failures = 0, checks_done = 0, cyc = 0, vo_n = 0, rb_n = 0, sr_n = 0, ps_n = 0;
  int gap_c = 0, last_gap = 0;

  always #10 clk = ~clk;

  maint_cmd #(.FW_RELEASE(FWR), .FW_DATE(FWD), .PRODUCT_ID(PID), .HW_RELEASE(HWR),
    .SLOW_HALF(8), .FAST_HALF(2)) i_maint_cmd (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_evt, .chip_status,
    .upd_byte_valid, .upd_port, .upd_last, .prog_done, .key8_held, .nv_next_img,
    .nv_prev_img(1'h0), .irq, .host_control_lamp, .manual_mode_lamp, .verbose_off,
    .boot_select, .img_in_use, .reboot, .settings_reset, .prog_start, .display_char);
  update_host #(.PROG_CYC(40)) i_update_host (.clk, .prog_start, .upd_byte_valid, .upd_port,
    .upd_last, .prog_done);

  // Storage keeps the boot selection; pulse counters and lamp half-period monitor
  always @(posedge clk)
  begin
    nv_next_img <= boot_select;
    lamp_q <= host_control_lamp;
    gap_c <= (host_control_lamp != lamp_q) ? 1 : gap_c + 1;
    if (host_control_lamp != lamp_q)
      last_gap <= gap_c;
    vo_n <= vo_n + int'(verbose_off === 1'h1);
    rb_n <= rb_n + int'(reboot === 1'h1);
    sr_n <= sr_n + int'(settings_reset === 1'h1);
    ps_n <= ps_n + int'(prog_start === 1'h1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write and read hold every request until its own ready, as the bus demands
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'h1)
      begin
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      n++;
    end
    while (s_axi_bvalid !== 1'h1 && n < 50);
    if (n >= 50)
      failures++;
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
      n++;
    end
    while (s_axi_rvalid !== 1'h1 && n < 50);
    if (n >= 50)
      failures++;
    rd_d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a, maint_pkg::RESP_OKAY);
    chk(rd_d & m, e);
  endtask
  task automatic cmd(input logic [12:0] w);
    wr(maint_pkg::CMD_OFS, {19'h0, w}, maint_pkg::RESP_OKAY);
  endtask

  initial
  begin
    int b, s, n;
    cy(5);
    rst_b <= 1'h1;
    cy(3);
    cmd(13'h0005);
    rc(maint_pkg::RPL0_OFS, 32'(maint_pkg::MSG_NO_ERROR), 32'hff);
    wr(maint_pkg::IRQ_STAT_OFS, 32'hf, maint_pkg::RESP_OKAY);
    fault_evt <= 5'h0a;
    cy(1);
    fault_evt <= 5'h00;
    rc(maint_pkg::FAULT_OFS, 32'h0a, 32'hff);
    cmd(13'h0005);
    rc(maint_pkg::RPL0_OFS, 32'(maint_pkg::MSG_BUSY), 32'hff);
    cmd(13'h0004);
    rc(maint_pkg::RPL0_OFS, 32'h3041, 32'hffff);
    chk(32'(irq), 32'h0);
    wr(maint_pkg::IRQ_MASK_OFS, 32'h1, maint_pkg::RESP_OKAY);
    cy(2);
    chk(32'(irq), 32'h1);
    wr(maint_pkg::IRQ_STAT_OFS, 32'h1, maint_pkg::RESP_OKAY);
    cy(2);
    chk(32'(irq), 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      b = (k < 4) ? k : 7;
      fault_evt <= 5'h1f;
      cy(1);
      fault_evt <= 5'h00;
      cmd({1'h1, b[3:0], 8'h06});
      rc(maint_pkg::FAULT_OFS, 32'h8f & ~(32'h1 << b), 32'hff);
      cmd(13'h0006);
    end
    rc(maint_pkg::FAULT_OFS, 32'h0, 32'hff);
    cmd(13'h0003);
    rc(maint_pkg::RPL0_OFS, 32'h2222_1111, 32'hffff_ffff);
    rc(maint_pkg::RPL1_OFS, 32'h4444_3333, 32'hffff_ffff);
    cmd(13'h0002);
    rc(maint_pkg::RPL0_OFS, HWR, 32'hffff_ffff);
    chk({24'h0, display_char}, {24'h0, HWR[31:24]});
    cmd(13'h0001);
    rc(maint_pkg::RPL0_OFS, FWR, 32'hffff_ffff);
    rc(maint_pkg::RPL1_OFS, FWD, 32'hffff_ffff);
    rc(maint_pkg::RPL2_OFS, PID, 32'hffff_ffff);
    rd(6'h3c, maint_pkg::RESP_SLVERR);
    chk(rd_d, 32'h0);
    wr(6'h3c, 32'h1, maint_pkg::RESP_SLVERR);
    wr(maint_pkg::IRQ_STAT_OFS, 32'hf, maint_pkg::RESP_OKAY);
    i_update_host.send(maint_pkg::PORT_SERIAL, 1, 2, 1'h1);
    rc(maint_pkg::IRQ_STAT_OFS, 32'h2, 32'h2);
    rc(maint_pkg::STAT_OFS, 32'h0, 32'h30);
    wr(maint_pkg::CFG_OFS, 32'h1, maint_pkg::RESP_OKAY);
    // Pulse counter settles one edge after the write returns
    cy(1);
    chk(32'(vo_n), 32'h1);
    i_update_host.send(maint_pkg::PORT_LAN_FAST, 1, 2, 1'h1);
    rc(maint_pkg::STAT_OFS, 32'h0, 32'h30);
    i_update_host.send(maint_pkg::PORT_LAN_NORMAL, 4, 12, 1'h0);
    chk(32'(last_gap), 32'h8);
    rc(maint_pkg::STAT_OFS, 32'h10, 32'h30);
    i_update_host.send(maint_pkg::PORT_LAN_NORMAL, 1, 0, 1'h1);
    cy(12);
    chk(32'(last_gap), 32'h2);
    chk(32'(ps_n), 32'h1);
    for (n = 0; n < 100 && manual_mode_lamp !== 1'h1; n++)
      cy(1);
    chk({31'h0, host_control_lamp}, 32'h0);
    chk({31'h0, manual_mode_lamp}, 32'h1);
    rc(maint_pkg::CFG_OFS, 32'h0, 32'h1);
    cmd(13'h0009);
    rc(maint_pkg::STAT_OFS, 32'h4, 32'h4);
    cmd(13'h0007);
    rc(maint_pkg::RPL0_OFS, 32'h0, 32'h1);
    cmd(13'h000a);
    cy(8);
    chk(32'(rb_n), 32'h1);
    chk(32'(sr_n), 32'h1);
    chk({31'h0, img_in_use}, 32'h1);
    key8_held <= 1'h1;
    cmd(13'h000a);
    cy(8);
    key8_held <= 1'h0;
    chk({31'h0, img_in_use}, 32'h0);
    wr(maint_pkg::CFG_OFS, 32'h6, maint_pkg::RESP_OKAY);
    s = sr_n;
    cmd(13'h000a);
    cy(8);
    chk(32'(sr_n), 32'(s));
    chk({31'h0, img_in_use}, 32'h1);
    summarize();
  end
endmodule

// [update_host.sv]
// Host-side model: sends update file bytes and answers nonvolatile writes
`timescale 1ns/1ps
module update_host #(
  parameter int PROG_CYC = 40
) (
  input wire logic clk,  // System clock
  input wire logic prog_start,  // Storage write begins
  output logic upd_byte_valid,  // Byte strobe
  output logic [1:0] upd_port,  // Source port
  output logic upd_last,  // Final byte
  output logic prog_done  // Storage write finished
);
  initial
  begin
    upd_byte_valid = 1'h0;
    upd_port = 2'h0;
    upd_last = 1'h0;
    prog_done = 1'h0;
  end
  // A slow host spaces bytes out; the gap sets how long slow blinking lasts
  task automatic send(input logic [1:0] port, input int n, input int gap, input logic last);
    for (int i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge clk);
      upd_byte_valid <= 1'h1;
      upd_port <= port;
      upd_last <= last && (i == n - 1);
      @(posedge clk);
      upd_byte_valid <= 1'h0;
      upd_last <= 1'h0;
      upd_port <= ~port;
    end
    @(posedge clk);
  endtask
  // Storage write takes a fixed while, then reports completion once
  always @(posedge clk)
    if (prog_start === 1'h1)
      fork
        begin
          repeat (PROG_CYC) @(posedge clk);
          prog_done <= 1'h1;
          @(posedge clk);
          prog_done <= 1'h0;
        end
      join_none
endmodule
